// ---- design/cpu_subset_pkg.sv ----
// shared constants, opcodes and register map for the instruction subset core
package cpu_subset_pkg;

  // widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int ROM_AW = 11;
  localparam int ROM_DW = 14;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;
  localparam int TPH_USED_W = 3;
  localparam int TDH_W = 6;
  localparam int OP_W = 3;
  localparam int FLAG_W = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_WREG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TPH = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_TDH = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_TMODE = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;

  // file register window 0x200..0x3FC, one byte per word
  localparam int FILE_REGION_LSB = 9;
  localparam logic [2:0] FILE_REGION = 3'h1;
  localparam int FILE_IDX_LSB = 2;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IMM_LSB = 8;
  localparam int CMD_FADDR_LSB = 16;
  localparam int CMD_DEST_BIT = 24;

  // opcodes
  localparam logic [OP_W-1:0] OPC_SUB_IMM = 3'h1;
  localparam logic [OP_W-1:0] OPC_TABLE = 3'h2;
  localparam logic [OP_W-1:0] OPC_LOAD_TMODE = 3'h3;
  localparam logic [OP_W-1:0] OPC_READ_TMODE = 3'h4;
  localparam logic [OP_W-1:0] OPC_XOR_FILE = 3'h5;
  localparam logic [OP_W-1:0] OPC_XOR_IMM = 3'h6;

  // flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;

  // status bit positions
  localparam int STAT_BUSY = 0;

  // reset values
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 3'h0;
  localparam logic [ROM_AW-1:0] RST_ROM_ADDR = 11'h000;
  localparam logic [TDH_W-1:0] RST_TDH = 6'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [0:0] {ST_IDLE, ST_TABLE} exec_state_e;

endpackage

// ---- design/cpu_subset_alu.sv ----
// byte alu: subtract with borrow flags, or exclusive-or
`timescale 1ns/1ps
module cpu_subset_alu
  import cpu_subset_pkg::*;
(
  // operands: a is the immediate or file byte, b the working register
  input wire logic [BYTE_W-1:0] i_a,
  input wire logic [BYTE_W-1:0] i_b,
  input wire logic i_sub,
  // result and flags
  output logic [BYTE_W-1:0] o_res,
  output logic o_zero,
  output logic o_half,
  output logic o_carry
);

  logic [BYTE_W:0] diff;
  logic [NIB_W:0] diff_lo;

  // one extra bit catches the borrow out of each width
  always_comb begin
    diff = {1'b0, i_a} - {1'b0, i_b};
    diff_lo = {1'b0, i_a[NIB_W-1:0]} - {1'b0, i_b[NIB_W-1:0]};
    o_res = i_sub ? diff[BYTE_W-1:0] : (i_a ^ i_b);
    o_zero = (o_res == RST_BYTE);
    o_half = ~diff_lo[NIB_W]; // set when the low nibble needs no borrow
    o_carry = ~diff[BYTE_W]; // inverted borrow
  end

endmodule

// ---- design/cpu_subset_file.sv ----
// file register bank: one write port, one combinational read port
`timescale 1ns/1ps
module cpu_subset_file
  import cpu_subset_pkg::*;
(
  // clock
  input wire logic i_clk,
  // write port
  input wire logic i_we,
  input wire logic [FILE_AW-1:0] i_waddr,
  input wire logic [BYTE_W-1:0] i_wdata,
  // read port
  input wire logic [FILE_AW-1:0] i_raddr,
  output logic [BYTE_W-1:0] o_rdata
);

  logic [BYTE_W-1:0] mem [FILE_DEPTH];

  // plain storage without reset, contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule

// ---- design/cpu_instr_subset_exec.sv ----
// execution core for a subset of instructions, driven over apb
// Function
// - subtract wreg from immediate, update z dc c
// - carry is inverted borrow of the subtraction
// - table address pointer[2:0] over wreg, low byte
// - rom bits 13..8 to data high, flags kept
// - load timer mode from wreg, one cycle
// - read timer mode into wreg, flags kept
// - xor wreg with file, z only, dest0 wreg
// - xor with file, dest1 writes file back
// - xor immediate into wreg, z only, one cycle
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module cpu_instr_subset_exec
  import cpu_subset_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  output logic [DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // program rom, combinational read
  output logic [ROM_AW-1:0] O_ROM_ADDR,
  output logic O_ROM_EN,
  input wire logic [ROM_DW-1:0] I_ROM_DATA,
  // timer mode towards the timer
  output logic [BYTE_W-1:0] O_TMR_MODE
);

  exec_state_e state;
  logic ready;
  logic slverr;
  logic [DATA_W-1:0] rdata;
  logic [BYTE_W-1:0] wreg;
  logic [FLAG_W-1:0] flags;
  logic [BYTE_W-1:0] table_pointer_high;
  logic [TDH_W-1:0] table_data_high;
  logic [BYTE_W-1:0] timer_zero_mode_reg;
  logic [ROM_AW-1:0] rom_addr;
  logic rom_en;

  logic access;
  logic done;
  logic wr_ok;
  logic busy;
  logic is_cmd;
  logic is_wreg;
  logic is_flags;
  logic is_tph;
  logic is_tdh;
  logic is_tmode;
  logic is_status;
  logic in_file;
  logic mapped;
  logic read_only;
  logic op_valid;
  logic next_err;
  logic [DATA_W-1:0] next_rdata;
  logic [OP_W-1:0] cmd_op;
  logic [BYTE_W-1:0] cmd_imm;
  logic [FILE_AW-1:0] cmd_faddr;
  logic cmd_dest;
  logic [FILE_AW-1:0] file_idx;
  logic exec_go;
  logic go_sub;
  logic go_table;
  logic go_load_tm;
  logic go_read_tm;
  logic go_xor_file;
  logic go_xor_imm;
  logic [BYTE_W-1:0] alu_a;
  logic [BYTE_W-1:0] alu_res;
  logic alu_zero;
  logic alu_half;
  logic alu_carry;
  logic file_we;
  logic [FILE_AW-1:0] file_waddr;
  logic [BYTE_W-1:0] file_wdata;
  logic [FILE_AW-1:0] file_raddr;
  logic [BYTE_W-1:0] file_rdata;

  // apb phase tracking
  assign access = I_PSEL & I_PENABLE;
  assign done = access & ready;
  assign busy = (state == ST_TABLE);

  // address decode
  assign is_cmd = (I_PADDR == OFS_CMD);
  assign is_wreg = (I_PADDR == OFS_WREG);
  assign is_flags = (I_PADDR == OFS_FLAGS);
  assign is_tph = (I_PADDR == OFS_TPH);
  assign is_tdh = (I_PADDR == OFS_TDH);
  assign is_tmode = (I_PADDR == OFS_TMODE);
  assign is_status = (I_PADDR == OFS_STATUS);
  assign in_file = (I_PADDR[ADDR_W-1:FILE_REGION_LSB] == FILE_REGION) &&
                   (I_PADDR[FILE_IDX_LSB-1:0] == 2'h0);
  assign file_idx = I_PADDR[FILE_IDX_LSB +: FILE_AW];
  assign mapped = is_cmd | is_wreg | is_flags | is_tph | is_tdh |
                  is_tmode | is_status | in_file;
  assign read_only = is_tdh | is_status;

  // command word fields
  assign cmd_op = I_PWDATA[CMD_OP_LSB +: OP_W];
  assign cmd_imm = I_PWDATA[CMD_IMM_LSB +: BYTE_W];
  assign cmd_faddr = I_PWDATA[CMD_FADDR_LSB +: FILE_AW];
  assign cmd_dest = I_PWDATA[CMD_DEST_BIT];

  // only the six opcodes of this core are accepted
  always_comb begin
    case (cmd_op)
      OPC_SUB_IMM,
      OPC_TABLE,
      OPC_LOAD_TMODE,
      OPC_READ_TMODE,
      OPC_XOR_FILE,
      OPC_XOR_IMM: op_valid = 1'b1;
      default: op_valid = 1'b0;
    endcase
  end

  // error: unmapped, write to read-only, bad opcode, any write while busy
  always_comb begin
    next_err = ~mapped;
    if (I_PWRITE) begin
      if (read_only | busy) begin
        next_err = 1'b1;
      end
      if (is_cmd & ~op_valid) begin
        next_err = 1'b1;
      end
    end
  end

  // read data mux, unused bits read zero
  always_comb begin
    next_rdata = RST_WORD;
    if (is_wreg) begin
      next_rdata[BYTE_W-1:0] = wreg;
    end
    if (is_flags) begin
      next_rdata[FLAG_W-1:0] = flags;
    end
    if (is_tph) begin
      next_rdata[BYTE_W-1:0] = table_pointer_high;
    end
    if (is_tdh) begin
      next_rdata[TDH_W-1:0] = table_data_high;
    end
    if (is_tmode) begin
      next_rdata[BYTE_W-1:0] = timer_zero_mode_reg;
    end
    if (is_status) begin
      next_rdata[STAT_BUSY] = busy;
    end
    if (in_file) begin
      next_rdata[BYTE_W-1:0] = file_rdata;
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ready <= 1'b0;
    end else begin
      ready <= access & ~ready;
    end
  end

  // error and read data are latched one edge ahead so they stand with ready
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      slverr <= 1'b0;
      rdata <= RST_WORD;
    end else if (access & ~ready) begin
      slverr <= next_err;
      rdata <= I_PWRITE ? RST_WORD : next_rdata;
    end else begin
      slverr <= 1'b0;
    end
  end

  // a refused write changes nothing
  assign wr_ok = done & I_PWRITE & ~slverr;
  assign exec_go = wr_ok & is_cmd;
  assign go_sub = exec_go & (cmd_op == OPC_SUB_IMM);
  assign go_table = exec_go & (cmd_op == OPC_TABLE);
  assign go_load_tm = exec_go & (cmd_op == OPC_LOAD_TMODE);
  assign go_read_tm = exec_go & (cmd_op == OPC_READ_TMODE);
  assign go_xor_file = exec_go & (cmd_op == OPC_XOR_FILE);
  assign go_xor_imm = exec_go & (cmd_op == OPC_XOR_IMM);

  // the file operand comes from the command while executing
  assign file_raddr = is_cmd ? cmd_faddr : file_idx;
  assign alu_a = (cmd_op == OPC_XOR_FILE) ? file_rdata : cmd_imm;

  cpu_subset_alu u_alu (
    .i_a(alu_a),
    .i_b(wreg),
    .i_sub(cmd_op == OPC_SUB_IMM),
    .o_res(alu_res),
    .o_zero(alu_zero),
    .o_half(alu_half),
    .o_carry(alu_carry)
  );

  // file write: xor write-back or bus write
  assign file_we = (go_xor_file & cmd_dest) | (wr_ok & in_file);
  assign file_waddr = in_file ? file_idx : cmd_faddr;
  assign file_wdata = in_file ? I_PWDATA[BYTE_W-1:0] : alu_res;

  cpu_subset_file u_file (
    .i_clk(I_CORE_CLK),
    .i_we(file_we),
    .i_waddr(file_waddr),
    .i_wdata(file_wdata),
    .i_raddr(file_raddr),
    .o_rdata(file_rdata)
  );

  // table read sequencer, the only two-cycle operation
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go_table) begin
            state <= ST_TABLE;
          end
        end
        ST_TABLE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // rom address is presented for the whole table cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rom_addr <= RST_ROM_ADDR;
      rom_en <= 1'b0;
    end else begin
      rom_en <= go_table;
      if (go_table) begin
        rom_addr <= {table_pointer_high[TPH_USED_W-1:0], wreg};
      end
    end
  end

  // working register
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wreg <= RST_BYTE;
    end else if (busy) begin
      wreg <= I_ROM_DATA[BYTE_W-1:0];
    end else if (go_sub) begin
      wreg <= alu_res;
    end else if (go_read_tm) begin
      wreg <= timer_zero_mode_reg;
    end else if (go_xor_file & ~cmd_dest) begin
      wreg <= alu_res;
    end else if (go_xor_imm) begin
      wreg <= alu_res;
    end else if (wr_ok & is_wreg) begin
      wreg <= I_PWDATA[BYTE_W-1:0];
    end
  end

  // status flags: table and timer mode moves leave them alone
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flags <= RST_FLAGS;
    end else if (go_sub) begin
      flags[FLAG_Z] <= alu_zero;
      flags[FLAG_DC] <= alu_half;
      flags[FLAG_C] <= alu_carry;
    end else if (go_xor_file | go_xor_imm) begin
      flags[FLAG_Z] <= alu_zero;
    end else if (wr_ok & is_flags) begin
      flags <= I_PWDATA[FLAG_W-1:0];
    end
  end

  // table pointer high, only its low bits reach the rom
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      table_pointer_high <= RST_BYTE;
    end else if (wr_ok & is_tph) begin
      table_pointer_high <= I_PWDATA[BYTE_W-1:0];
    end
  end

  // table data high catches the top six rom bits
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      table_data_high <= RST_TDH;
    end else if (busy) begin
      table_data_high <= I_ROM_DATA[ROM_DW-1:BYTE_W];
    end
  end

  // timer mode register
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      timer_zero_mode_reg <= RST_BYTE;
    end else if (go_load_tm) begin
      timer_zero_mode_reg <= wreg;
    end else if (wr_ok & is_tmode) begin
      timer_zero_mode_reg <= I_PWDATA[BYTE_W-1:0];
    end
  end

  // outputs straight from flops
  assign O_PRDATA = rdata;
  assign O_PREADY = ready;
  assign O_PSLVERR = slverr;
  assign O_ROM_ADDR = rom_addr;
  assign O_ROM_EN = rom_en;
  assign O_TMR_MODE = timer_zero_mode_reg;

endmodule

// ---- verification/exec_checker.sv ----
// port assertions for the instruction subset core
`timescale 1ns/1ps
module exec_checker
  import cpu_subset_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  input wire logic [DATA_W-1:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // rom and timer
  input wire logic [ROM_AW-1:0] O_ROM_ADDR,
  input wire logic O_ROM_EN,
  input wire logic [ROM_DW-1:0] I_ROM_DATA,
  input wire logic [BYTE_W-1:0] O_TMR_MODE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // a write completing at this edge, and the opcode it carries
  wire acc = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  wire [OP_W-1:0] op = I_PWDATA[OP_W-1:0];
  wire cmd = acc && I_PADDR == OFS_CMD;

  one_wait_a: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  write_zero_a: assert property (O_PREADY && I_PWRITE |-> O_PRDATA == RST_WORD)
    else $error("read data not zero on write");
  bad_opcode_a: assert property (cmd && (op == 3'h0 || op == 3'h7) |-> O_PSLVERR)
    else $error("bad opcode accepted");
  ro_refused_a: assert property (acc && (I_PADDR == OFS_TDH || I_PADDR == OFS_STATUS)
    |-> O_PSLVERR) else $error("read-only write accepted");
  unmapped_a: assert property (O_PREADY && I_PADDR == 12'h100 |-> O_PSLVERR && O_PRDATA == 0)
    else $error("unmapped access not refused");
  table_fetch_a: assert property (cmd && op == OPC_TABLE |=> O_ROM_EN ##1 !O_ROM_EN)
    else $error("table read did not fetch once");
  fetch_cause_a: assert property (O_ROM_EN |-> $past(cmd && op == OPC_TABLE))
    else $error("rom fetch without table read");
  tmode_hold_a: assert property (!(acc && (I_PADDR == OFS_TMODE ||
    I_PADDR == OFS_CMD && op == OPC_LOAD_TMODE)) |=> $stable(O_TMR_MODE))
    else $error("timer mode changed");

  // main scenarios reached
  cov_table_c: cover property (cmd && op == OPC_TABLE);
  cov_err_c: cover property (O_PSLVERR);
  cov_xor_c: cover property (cmd && op == OPC_XOR_FILE && I_PWDATA[CMD_DEST_BIT]);
endmodule

bind cpu_instr_subset_exec exec_checker chk (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_ROM_ADDR(O_ROM_ADDR), .O_ROM_EN(O_ROM_EN), .I_ROM_DATA(I_ROM_DATA),
  .O_TMR_MODE(O_TMR_MODE));

// ---- verification/rom_model.sv ----
// program rom model with 14-bit words
`timescale 1ns/1ps
module rom_model
  import cpu_subset_pkg::*;
(
  // rom port
  input wire logic [ROM_AW-1:0] i_addr,
  input wire logic i_en,
  output logic [ROM_DW-1:0] o_data
);
  // contents follow from the address, so every word is predictable
  function automatic logic [ROM_DW-1:0] word(input logic [ROM_AW-1:0] a);
    return {a[10:5] ^ 6'h15, a[7:0] ^ 8'hC3};
  endfunction
  // inverse shown outside a fetch, so a mistimed sample is caught
  assign o_data = i_en ? word(i_addr) : ~word(i_addr);
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the instruction subset core
`timescale 1ns/1ps
module tb_top
  import cpu_subset_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rd;
  logic pready, pslverr, er, rom_en;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data, w14;
  logic [BYTE_W-1:0] tmr;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  logic [ADDR_W-1:0] ofs [6] = '{OFS_WREG, OFS_FLAGS, OFS_TPH, OFS_TDH, OFS_TMODE, OFS_STATUS};
  // w, imm, result, flags
  logic [31:0] sub_t [4] = '{32'h0605FF00, 32'h05060103, 32'h38420A01, 32'h07070007};

  cpu_instr_subset_exec dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_ROM_ADDR(rom_addr),
    .O_ROM_EN(rom_en), .I_ROM_DATA(rom_data), .O_TMR_MODE(tmr));
  rom_model rom (.i_addr(rom_addr), .i_en(rom_en), .o_data(rom_data));

  // free-running clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic results();
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // apb transfer, entered right after a rising edge; request held until ready
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", 32'(e), 32'(er));
  endtask

  task automatic rdc(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("pslverr", 32'h0, 32'(er));
  endtask

  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [7:0] imm,
    input logic [6:0] fa, input logic d);
    return {7'h00, d, 1'b0, fa, imm, 5'h00, op};
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rdc("reset value", ofs[i], RST_WORD);
    // subtract table, both borrow directions and a zero result
    foreach (sub_t[i]) begin
      wr(OFS_WREG, 32'(sub_t[i][31:24]), 1'b0);
      wr(OFS_CMD, cmd(OPC_SUB_IMM, sub_t[i][23:16], 7'h00, 1'b0), 1'b0);
      rdc("sub wreg", OFS_WREG, 32'(sub_t[i][15:8]));
      rdc("sub flags", OFS_FLAGS, 32'(sub_t[i][7:0]));
    end
    // table read, pointer upper bits must be ignored
    wr(OFS_FLAGS, 32'h5, 1'b0);
    wr(OFS_TPH, 32'hFA, 1'b0);
    wr(OFS_WREG, 32'h34, 1'b0);
    wr(OFS_CMD, cmd(OPC_TABLE, 8'h00, 7'h00, 1'b0), 1'b0);
    w14 = {6'h04, 8'hF7}; // rom word at 0x234, worked out from the model's address pattern
    chk("rom addr", 32'h234, 32'(rom_addr));
    rdc("table low", OFS_WREG, 32'(w14[7:0]));
    rdc("table high", OFS_TDH, 32'(w14[13:8]));
    rdc("table flags", OFS_FLAGS, 32'h5);
    // refused writes leave state alone
    wr(OFS_TDH, 32'h3F, 1'b1);
    wr(OFS_STATUS, 32'h1, 1'b1);
    wr(OFS_CMD, cmd(3'h0, 8'h00, 7'h00, 1'b0), 1'b1);
    wr(OFS_CMD, cmd(3'h7, 8'h00, 7'h00, 1'b0), 1'b1);
    rdc("tdh kept", OFS_TDH, 32'(w14[13:8]));
    rdc("wreg kept", OFS_WREG, 32'(w14[7:0]));
    wr(12'h100, 32'h1, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    // timer mode load and read back
    wr(OFS_FLAGS, 32'h3, 1'b0);
    wr(OFS_WREG, 32'hAA, 1'b0);
    wr(OFS_CMD, cmd(OPC_LOAD_TMODE, 8'h00, 7'h00, 1'b0), 1'b0);
    chk("tmr port", 32'hAA, 32'(tmr));
    wr(OFS_WREG, 32'h11, 1'b0);
    wr(OFS_CMD, cmd(OPC_READ_TMODE, 8'h00, 7'h00, 1'b0), 1'b0);
    rdc("tmode wreg", OFS_WREG, 32'hAA);
    rdc("tmode kept", OFS_TMODE, 32'hAA);
    rdc("tmode flags", OFS_FLAGS, 32'h3);
    // xor with file register, both destinations
    wr(12'h214, 32'hA5, 1'b0);
    wr(OFS_WREG, 32'hF0, 1'b0);
    wr(OFS_FLAGS, 32'h7, 1'b0);
    wr(OFS_CMD, cmd(OPC_XOR_FILE, 8'h00, 7'h05, 1'b1), 1'b0);
    rdc("xor file", 12'h214, 32'h55);
    rdc("xor wreg kept", OFS_WREG, 32'hF0);
    rdc("xor flags", OFS_FLAGS, 32'h3);
    wr(OFS_CMD, cmd(OPC_XOR_FILE, 8'h00, 7'h05, 1'b0), 1'b0);
    rdc("xor wreg", OFS_WREG, 32'hA5);
    rdc("xor file kept", 12'h214, 32'h55);
    // xor immediate, zero then non-zero
    wr(OFS_CMD, cmd(OPC_XOR_IMM, 8'hA5, 7'h00, 1'b0), 1'b0);
    rdc("xori wreg", OFS_WREG, 32'h0);
    rdc("xori flags", OFS_FLAGS, 32'h7);
    wr(OFS_CMD, cmd(OPC_XOR_IMM, 8'h5A, 7'h00, 1'b0), 1'b0);
    rdc("xori wreg", OFS_WREG, 32'h5A);
    rdc("xori flags", OFS_FLAGS, 32'h3);
    results();
  end
endmodule
